// ==== include/xef_pkg.sv ====
// Constants, opcodes and carrier types for the XOR execute and flag block.
// Assumes a decode stage presents a whole instruction and a memory-side port.
package xef_pkg;
  localparam logic [4:0] XEF_OP_XOR_REG   = 5'h0d;
  localparam logic [7:0] XEF_OP_XOR_DIR   = 8'h65;
  localparam logic [7:0] XEF_OP_XOR_IMM_M = 8'h63;
  localparam logic [7:0] XEF_OP_XOR_ACC_M = 8'h62;
  localparam logic [7:0] XEF_OP_XOR_IMM_A = 8'h64;
  localparam logic [6:0] XEF_OP_XOR_IND   = 7'h33;
  localparam logic [7:0] XEF_OP_ADD_DIR   = 8'h25;
  localparam logic [7:0] XEF_OP_SUB_DIR   = 8'h95;
  localparam logic [7:0] XEF_OP_PUSH_PC   = 8'h12;
  localparam logic [7:0] XEF_OP_POP_PC    = 8'h22;
  localparam logic [7:0] XEF_OP_BRANCH    = 8'h80;
  localparam int         XEF_PSW_CY       = 7;
  localparam int         XEF_PSW_AC       = 6;
  localparam int         XEF_PSW_OV       = 2;
  localparam int         XEF_PSW_P        = 0;
  localparam logic [7:0] XEF_RAM_LIMIT    = 8'h7f;
  localparam logic [7:0] XEF_ACC_RST      = 8'h00;
  localparam logic [7:0] XEF_PSW_RST      = 8'h00;
  localparam logic [7:0] XEF_SP_RST       = 8'h07;
  localparam logic [15:0] XEF_PC_RST      = 16'h0000;
  localparam int         XEF_NPORT        = 4;
  localparam logic [7:0] XEF_PORT_BASE    = 8'h80;
  localparam logic [7:0] XEF_PORT_STEP    = 8'h10;
  localparam logic [7:0] XEF_LATCH_RST    = 8'hff;
  localparam logic [7:0] XEF_UNDEF        = 8'h00;

  typedef struct packed {
    logic       valid;
    logic [7:0] opcode;
    logic [7:0] byte1;
    logic [7:0] byte2;
    logic [2:0] len;
  } xef_instr_t;

  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] wdata;
  } xef_mem_wr_t;
endpackage

// ==== rtl/xef_core.sv ====
// XOR execute datapath with flag, port, stack and branch handling.
// Assumes instructions come from a same-clock decode stage; RAM reads are combinational.
`timescale 1ns/1ps
module xef_core (
  // Clock and reset
  input  wire logic                 clock_i,
  input  wire logic                 reset_n_i,
  // Instruction from decode
  input  wire xef_pkg::xef_instr_t  instr_i,
  // Working registers from the active bank
  input  wire logic [63:0]          working_regs_i,
  // Internal RAM read data at the presented instruction's address; at ram_raddr_o in later cycles
  input  wire logic [7:0]           ram_rdata_i,
  // Port pins, asynchronous
  input  wire logic [31:0]          port_pins_i,
  // Execution status
  output logic                      busy_o,
  output logic                      done_o,
  // Internal RAM access
  output logic [6:0]                ram_raddr_o,
  output xef_pkg::xef_mem_wr_t      ram_wr_o,
  // Architectural state
  output logic [7:0]                acc_o,
  output logic [7:0]                program_status_word_o,
  output logic [7:0]                sp_o,
  output logic [15:0]               pc_o,
  output logic [31:0]               port_latch_o
);
  import xef_pkg::*;

  typedef enum logic [1:0] {XEF_IDLE, XEF_RMW, XEF_POP_HI} xef_state_t;

  xef_state_t  state_r, state_nxt;
  logic [7:0]  acc_r, acc_nxt, psw_r, psw_nxt, sp_r, sp_nxt, tmp_r, tmp_nxt;
  logic [15:0] pc_r, pc_nxt;
  logic [7:0]  latch_r [XEF_NPORT];
  logic [7:0]  latch_nxt [XEF_NPORT];
  logic [31:0] pin_s1_r, pin_s2_r;
  logic        done_r, done_nxt;
  logic        busy_r, busy_nxt;
  xef_mem_wr_t wr_r, wr_nxt;
  logic [6:0]  raddr_r, raddr_nxt;

  function automatic int xef_port_idx(input logic [7:0] a);
    int k;
    k = -1;
    for (int i = 0; i < XEF_NPORT; i++) begin
      if (a == 8'(XEF_PORT_BASE + 8'(i) * XEF_PORT_STEP)) begin
        k = i;
      end
    end
    return k;
  endfunction

  // Pin synchroniser
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_s1_r <= 32'h0;
      pin_s2_r <= 32'h0;
    end else begin
      pin_s1_r <= port_pins_i;
      pin_s2_r <= pin_s1_r;
    end
  end

  // Direct read: pins for pure source, latch for read-modify-write
  function automatic logic [7:0] xef_dir_read(input logic [7:0] a, input logic rmw,
                                              input logic [7:0] lt [XEF_NPORT],
                                              input logic [31:0] pins,
                                              input logic [7:0] ram);
    int k;
    k = xef_port_idx(a);
    if (k >= 0) begin
      return rmw ? lt[k] : pins[k*8 +: 8];
    end
    return (a > XEF_RAM_LIMIT) ? XEF_UNDEF : ram;
  endfunction

  always_comb begin
    logic [7:0]  op, src, res, a, b;
    logic [8:0]  sum;
    logic [4:0]  lo;
    logic [15:0] pcn;
    int          k;
    op = instr_i.opcode;
    a = acc_r;
    b = 8'h00;
    src = 8'h00;
    res = 8'h00;
    sum = 9'h0;
    lo = 5'h0;
    k = -1;
    pcn = 16'(pc_r + 16'(instr_i.len));
    state_nxt = state_r;
    acc_nxt = acc_r;
    psw_nxt = psw_r;
    sp_nxt = sp_r;
    pc_nxt = pc_r;
    tmp_nxt = tmp_r;
    done_nxt = 1'b0;
    wr_nxt = '0;
    raddr_nxt = instr_i.byte1[6:0];
    for (int i = 0; i < XEF_NPORT; i++) begin
      latch_nxt[i] = latch_r[i];
    end
    unique case (state_r)
      XEF_IDLE: begin
        if (instr_i.valid) begin
          pc_nxt = pcn;
          done_nxt = 1'b1;
          src = xef_dir_read(instr_i.byte1, 1'b0, latch_r, pin_s2_r, ram_rdata_i);
          if (op[7:3] == XEF_OP_XOR_REG) begin
            acc_nxt = acc_r ^ working_regs_i[op[2:0]*8 +: 8];
          end else if (op == XEF_OP_XOR_DIR) begin
            acc_nxt = acc_r ^ src;
          end else if (op == XEF_OP_XOR_IMM_A) begin
            acc_nxt = acc_r ^ instr_i.byte1;
          end else if (op[7:1] == XEF_OP_XOR_IND) begin
            acc_nxt = acc_r ^ ((working_regs_i[op[0]*8 +: 8] > XEF_RAM_LIMIT) ?
                               XEF_UNDEF : ram_rdata_i);
          end else if (op == XEF_OP_XOR_IMM_M) begin
            state_nxt = XEF_RMW;
            tmp_nxt = instr_i.byte2;
            done_nxt = 1'b0;
          end else if (op == XEF_OP_XOR_ACC_M) begin
            res = xef_dir_read(instr_i.byte1, 1'b1, latch_r, pin_s2_r, ram_rdata_i) ^ acc_r;
            k = xef_port_idx(instr_i.byte1);
            if (k >= 0) begin
              latch_nxt[k] = res;
            end else if (instr_i.byte1 <= XEF_RAM_LIMIT) begin
              wr_nxt = '{we: 1'b1, addr: instr_i.byte1[6:0], wdata: res};
            end
          end else if (op == XEF_OP_ADD_DIR) begin
            b = src;
            sum = 9'(a) + 9'(b);
            lo = 5'(a[3:0]) + 5'(b[3:0]);
            acc_nxt = sum[7:0];
            psw_nxt[XEF_PSW_CY] = sum[8];
            psw_nxt[XEF_PSW_AC] = lo[4];
            psw_nxt[XEF_PSW_OV] = (a[7] == b[7]) && (sum[7] != a[7]);
          end else if (op == XEF_OP_SUB_DIR) begin
            b = src;
            sum = 9'(a) - 9'(b) - 9'(psw_r[XEF_PSW_CY]);
            lo = 5'(a[3:0]) - 5'(b[3:0]) - 5'(psw_r[XEF_PSW_CY]);
            acc_nxt = sum[7:0];
            psw_nxt[XEF_PSW_CY] = sum[8];
            psw_nxt[XEF_PSW_AC] = lo[4];
            psw_nxt[XEF_PSW_OV] = (a[7] != b[7]) && (sum[7] != a[7]);
          end else if (op == XEF_OP_PUSH_PC) begin
            sp_nxt = 8'(sp_r + 8'h01);
            wr_nxt = '{we: (sp_nxt <= XEF_RAM_LIMIT), addr: sp_nxt[6:0], wdata: pcn[7:0]};
            tmp_nxt = pcn[15:8];
            state_nxt = XEF_RMW;
            done_nxt = 1'b0;
          end else if (op == XEF_OP_POP_PC) begin
            tmp_nxt = (sp_r > XEF_RAM_LIMIT) ? XEF_UNDEF : ram_rdata_i;
            sp_nxt = 8'(sp_r - 8'h01);
            raddr_nxt = sp_nxt[6:0];
            state_nxt = XEF_POP_HI;
            done_nxt = 1'b0;
          end else if (op == XEF_OP_BRANCH) begin
            pc_nxt = 16'(pcn + {{8{instr_i.byte1[7]}}, instr_i.byte1});
          end
          if (op == XEF_OP_POP_PC) begin
            raddr_nxt = sp_nxt[6:0];
          end else if (op[7:1] == XEF_OP_XOR_IND) begin
            raddr_nxt = working_regs_i[op[0]*8 +: 7];
          end
        end
      end
      XEF_RMW: begin
        done_nxt = 1'b1;
        state_nxt = XEF_IDLE;
        if (instr_i.opcode == XEF_OP_PUSH_PC) begin
          sp_nxt = 8'(sp_r + 8'h01);
          wr_nxt = '{we: (sp_nxt <= XEF_RAM_LIMIT), addr: sp_nxt[6:0], wdata: tmp_r};
        end else begin
          res = xef_dir_read(instr_i.byte1, 1'b1, latch_r, pin_s2_r, ram_rdata_i) ^ tmp_r;
          k = xef_port_idx(instr_i.byte1);
          if (k >= 0) begin
            latch_nxt[k] = res;
          end else if (instr_i.byte1 <= XEF_RAM_LIMIT) begin
            wr_nxt = '{we: 1'b1, addr: instr_i.byte1[6:0], wdata: res};
          end
        end
      end
      XEF_POP_HI: begin
        done_nxt = 1'b1;
        state_nxt = XEF_IDLE;
        pc_nxt = {tmp_r, (sp_r > XEF_RAM_LIMIT) ? XEF_UNDEF : ram_rdata_i};
        sp_nxt = 8'(sp_r - 8'h01);
      end
    endcase
    // XOR keeps arithmetic flags; parity follows result
    psw_nxt[XEF_PSW_P] = ^acc_nxt;
    busy_nxt = (state_nxt != XEF_IDLE);
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= XEF_IDLE;
      acc_r   <= XEF_ACC_RST;
      psw_r   <= XEF_PSW_RST;
      sp_r    <= XEF_SP_RST;
      pc_r    <= XEF_PC_RST;
      tmp_r   <= 8'h00;
      done_r  <= 1'b0;
      busy_r  <= 1'b0;
      wr_r    <= '0;
      raddr_r <= 7'h00;
      for (int i = 0; i < XEF_NPORT; i++) begin
        latch_r[i] <= XEF_LATCH_RST;
      end
    end else begin
      state_r <= state_nxt;
      acc_r   <= acc_nxt;
      psw_r   <= psw_nxt;
      sp_r    <= sp_nxt;
      pc_r    <= pc_nxt;
      tmp_r   <= tmp_nxt;
      done_r  <= done_nxt;
      busy_r  <= busy_nxt;
      wr_r    <= wr_nxt;
      raddr_r <= raddr_nxt;
      for (int i = 0; i < XEF_NPORT; i++) begin
        latch_r[i] <= latch_nxt[i];
      end
    end
  end

  always_comb begin
    busy_o                = busy_r;
    done_o                = done_r;
    ram_raddr_o           = raddr_r;
    ram_wr_o              = wr_r;
    acc_o                 = acc_r;
    program_status_word_o = psw_r;
    sp_o                  = sp_r;
    pc_o                  = pc_r;
    for (int i = 0; i < XEF_NPORT; i++) begin
      port_latch_o[i*8 +: 8] = latch_r[i];
    end
  end
endmodule

// ==== testbench/xef_core_props.sv ====
// Concurrent checks on the XOR execute block, attached by bind.
// Assumes RAM read data follows the fields of the presented instruction.
`timescale 1ns/1ps
module xef_core_props (
  // Clock and reset
  input wire logic                 clock_i,
  input wire logic                 reset_n_i,
  // Watched inputs
  input wire xef_pkg::xef_instr_t  instr_i,
  input wire logic [63:0]          working_regs_i,
  input wire logic [7:0]           ram_rdata_i,
  // Watched outputs
  input wire logic                 busy_o,
  input wire logic                 done_o,
  input wire xef_pkg::xef_mem_wr_t ram_wr_o,
  input wire logic [7:0]           acc_o,
  input wire logic [7:0]           program_status_word_o,
  input wire logic [15:0]          pc_o,
  input wire logic [31:0]          port_latch_o
);
  import xef_pkg::*;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  logic       tk, lo, xg, cy;
  logic [7:0] op, a, m, rv;
  logic [8:0] s, d;
  logic [4:0] h, b;
  assign tk = instr_i.valid && !busy_o;
  assign op = instr_i.opcode;
  assign lo = !instr_i.byte1[7];
  assign a  = acc_o;
  assign m  = ram_rdata_i;
  assign cy = program_status_word_o[7];
  assign rv = working_regs_i[op[2:0]*8 +: 8];
  assign s  = a + m;
  assign h  = a[3:0] + m[3:0];
  assign d  = a - m - cy;
  assign b  = a[3:0] - m[3:0] - cy;
  assign xg = op[7:3] == XEF_OP_XOR_REG || op[7:1] == XEF_OP_XOR_IND || op == XEF_OP_XOR_DIR
           || op == XEF_OP_XOR_IMM_M || op == XEF_OP_XOR_ACC_M || op == XEF_OP_XOR_IMM_A;
  sequence s_busy_wr; busy_o ##1 (done_o && ram_wr_o.we); endsequence
  property p_par; program_status_word_o[0] == ^acc_o; endproperty
  a_par: assert property (p_par) else $error("parity flag wrong");
  property p_reg; tk && op[7:3] == XEF_OP_XOR_REG |=> done_o && acc_o == $past(a ^ rv); endproperty
  a_reg: assert property (p_reg) else $error("register xor wrong");
  property p_dir; tk && op == XEF_OP_XOR_DIR && lo |=> acc_o == $past(a ^ m); endproperty
  a_dir: assert property (p_dir) else $error("direct xor wrong");
  property p_imm;
    tk && op == XEF_OP_XOR_IMM_M && lo |=> s_busy_wr ##0
      ram_wr_o.wdata == $past(m ^ instr_i.byte2, 2) &&
      ram_wr_o.addr == $past(instr_i.byte1[6:0], 2);
  endproperty
  a_imm: assert property (p_imm) else $error("immediate to memory wrong");
  property p_acm;
    tk && op == XEF_OP_XOR_ACC_M && lo |=> ram_wr_o.we &&
      ram_wr_o.wdata == $past(a ^ m) && $stable(acc_o);
  endproperty
  a_acm: assert property (p_acm) else $error("accumulator to memory wrong");
  property p_flg;
    tk && xg |=> $stable({program_status_word_o[7:6], program_status_word_o[2]});
  endproperty
  a_flg: assert property (p_flg) else $error("xor touched arithmetic flags");
  property p_add;
    tk && op == XEF_OP_ADD_DIR && lo |=> {program_status_word_o[7:6], program_status_word_o[2]}
      == $past({s[8], h[4], a[7] == m[7] && s[7] != a[7]});
  endproperty
  a_add: assert property (p_add) else $error("add flags wrong");
  property p_sub;
    tk && op == XEF_OP_SUB_DIR && lo |=> {program_status_word_o[6], program_status_word_o[2]}
      == $past({b[4], a[7] != m[7] && d[7] != a[7]});
  endproperty
  a_sub: assert property (p_sub) else $error("subtract flags wrong");
  property p_bra;
    tk && op == XEF_OP_BRANCH |=>
      pc_o == $past(pc_o + instr_i.len + {{8{instr_i.byte1[7]}}, instr_i.byte1});
  endproperty
  a_bra: assert property (p_bra) else $error("branch target wrong");
  property p_prt;
    tk && op == XEF_OP_XOR_IMM_M && instr_i.byte1 == XEF_PORT_BASE |=> busy_o ##1
      port_latch_o[7:0] == $past(port_latch_o[7:0] ^ instr_i.byte2, 2);
  endproperty
  a_prt: assert property (p_prt) else $error("port latch update wrong");
endmodule
bind xef_core xef_core_props xef_core_props_inst (.*);

// ==== testbench/xef_mem_model.sv ====
// Internal data memory facing the XOR block, read from instruction fields.
// Assumes writes arrive as one-cycle strobes on the block's clock.
// Second cycle of a stack pop follows the block's read address.
`timescale 1ns/1ps
module xef_mem_model (
  // Clock
  input  wire logic                 clock_i,
  // Instruction and working registers
  input  wire xef_pkg::xef_instr_t  instr_i,
  input  wire logic [63:0]          working_regs_i,
  // Memory ports
  input  wire logic [6:0]           ram_raddr_i,
  input  wire xef_pkg::xef_mem_wr_t ram_wr_i,
  output logic [7:0]                ram_rdata_o
);
  import xef_pkg::*;
  logic [7:0] mem [128];
  logic [6:0] ra;
  logic       pop2_r;
  always @(posedge clock_i)
    pop2_r <= instr_i.valid && instr_i.opcode == XEF_OP_POP_PC && !pop2_r;
  always_comb begin
    ra = instr_i.byte1[6:0];
    if (instr_i.opcode[7:1] == XEF_OP_XOR_IND)
      ra = working_regs_i[instr_i.opcode[0]*8 +: 7];
    if (pop2_r)
      ra = ram_raddr_i;
    ram_rdata_o = mem[ra];
  end
  always @(posedge clock_i)
    if (ram_wr_i.we)
      mem[ram_wr_i.addr] <= ram_wr_i.wdata;
endmodule

// ==== testbench/xef_core_bench.sv ====
// Self-checking bench for the XOR execute block and its memory model.
// Assumes the checker is bound separately; inputs move at falling edges.
`timescale 1ns/1ps
module xef_core_bench;
  import xef_pkg::*;
  logic        clock_i, reset_n_i, busy, done;
  xef_instr_t  ins;
  xef_mem_wr_t wr;
  logic [63:0] regs;
  logic [31:0] pins, lat;
  logic [15:0] pc, p;
  logic [7:0]  rd, acc, program_status_word, sp, ea;
  logic [6:0]  raddr;
  int          n_errors, compares;
  xef_core xef_core_inst (.clock_i(clock_i), .reset_n_i(reset_n_i), .instr_i(ins),
    .working_regs_i(regs), .ram_rdata_i(rd), .port_pins_i(pins), .busy_o(busy),
    .done_o(done), .ram_raddr_o(raddr), .ram_wr_o(wr), .acc_o(acc),
    .program_status_word_o(program_status_word), .sp_o(sp), .pc_o(pc), .port_latch_o(lat));
  xef_mem_model xef_mem_model_inst (.clock_i(clock_i), .instr_i(ins),
    .working_regs_i(regs), .ram_raddr_i(raddr), .ram_wr_i(wr), .ram_rdata_o(rd));
  initial begin
    clock_i = 0;
    forever #10 clock_i = ~clock_i;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Immediate operands are always single bytes
  task automatic run(input logic [7:0] op, b1, b2, input logic [2:0] ln);
    @(negedge clock_i);
    ins = '{1'b1, op, b1, b2, ln};
    for (int i = 0; i < 6 && done !== 1'b1; i++)
      @(negedge clock_i);
    chk(done, 1'b1);
    ins.valid = 1'b0;
    // Registered write strobe lands in memory one edge after done
    @(negedge clock_i);
  endtask
  task automatic set_acc(input logic [7:0] v);
    run(XEF_OP_XOR_IMM_A, ea ^ v, 8'h00, 3'h2);
    ea = v;
  endtask
  task automatic t_reg;
    for (int r = 0; r < 8; r++) begin
      run({XEF_OP_XOR_REG, r[2:0]}, 8'h00, 8'h00, 3'h1);
      ea ^= regs[r*8 +: 8];
      chk(acc, ea);
      chk(program_status_word[0], ^ea);
    end
  endtask
  task automatic t_mem;
    run(XEF_OP_XOR_DIR, 8'h37, 8'h00, 3'h2);
    ea ^= 8'h88;
    chk(acc, ea);
    run(XEF_OP_XOR_IMM_M, 8'h10, 8'h5a, 3'h3);
    chk(xef_mem_model_inst.mem[7'h10], 8'h6b);
    run(XEF_OP_XOR_ACC_M, 8'h10, 8'h00, 3'h2);
    chk(xef_mem_model_inst.mem[7'h10], 8'h6b ^ ea);
    chk(acc, ea);
    run(XEF_OP_XOR_IMM_M, 8'h80, 8'h51, 3'h3);
    chk(lat[7:0], 8'hae);
    run(XEF_OP_XOR_DIR, 8'h90, 8'h00, 3'h2);
    ea ^= 8'h3c;
    chk(acc, ea);
    run(XEF_OP_XOR_ACC_M, 8'ha0, 8'h00, 3'h2);
    chk(lat[23:16], 8'hff ^ ea);
    run(8'h67, 8'h00, 8'h00, 3'h1);
    chk(acc, ea);
  endtask
  task automatic t_arith;
    set_acc(8'h88);
    run(XEF_OP_ADD_DIR, 8'h20, 8'h00, 3'h2);
    chk({program_status_word[7:6], program_status_word[2], acc}, 11'h710);
    ea = 8'h10;
    run(8'h6c, 8'h00, 8'h00, 3'h1);
    chk({program_status_word[7:6], program_status_word[2]}, 3'h7);
    ea ^= regs[39:32];
    set_acc(8'h76);
    run(XEF_OP_SUB_DIR, 8'h21, 8'h00, 3'h2);
    chk({program_status_word[7:6], program_status_word[2], acc}, 11'h070);
    run(XEF_OP_SUB_DIR, 8'h22, 8'h00, 3'h2);
    chk({program_status_word[7:6], program_status_word[2], acc}, 11'h7ef);
  endtask
  task automatic t_stack;
    p = pc;
    run(XEF_OP_BRANCH, 8'h80, 8'h00, 3'h2);
    chk(pc, p + 16'hff82);
    p = pc;
    run(XEF_OP_PUSH_PC, 8'h00, 8'h00, 3'h1);
    chk(sp, 8'h09);
    p = p + 16'h0001;
    chk(xef_mem_model_inst.mem[7'h09], p[15:8]);
    chk(xef_mem_model_inst.mem[7'h08], p[7:0]);
    run(XEF_OP_POP_PC, sp, 8'h00, 3'h1);
    chk(pc, p);
    chk(sp, 8'h07);
  endtask
  initial begin
    ins = '0;
    regs = 64'ha5_5a_3c_c3_0f_f0_90_10;
    pins = 32'h0000_3c00;
    reset_n_i = 1'b0;
    ea = 8'h00;
    for (int i = 0; i < 128; i++)
      xef_mem_model_inst.mem[i] = 8'h55;
    xef_mem_model_inst.mem[7'h37] = 8'h88;
    xef_mem_model_inst.mem[7'h10] = 8'h31;
    xef_mem_model_inst.mem[7'h20] = 8'h88;
    xef_mem_model_inst.mem[7'h21] = 8'h05;
    xef_mem_model_inst.mem[7'h22] = 8'h81;
    repeat (8) @(negedge clock_i);
    reset_n_i = 1'b1;
    t_reg;
    t_mem;
    t_arith;
    t_stack;
    test_done;
  end
  initial begin
    #40000;
    n_errors++;
    test_done;
  end
endmodule
